// File: verilog/fifo_params.svh
`ifndef FIFO_PARAMS_SVH
`define FIFO_PARAMS_SVH
// Buffer shape
`define FIFO_WIDTH 40
`define FIFO_DEPTH 16384
`define OFS_W 17
// Offset register reset values
`define AEMPTY_OFS_RST 17'h0007F
`define AFULL_OFS_RST 17'h0007F
// Host register byte offsets
`define REG_CTRL 8'h00
`define REG_WLO 8'h04
`define REG_WHI 8'h08
`define REG_RCMD 8'h0C
`define REG_RLO 8'h10
`define REG_RHI 8'h14
`define REG_STAT 8'h18
`define REG_OFS 8'h1C
// Control register fields and reset value
`define CTRL_FALL 0
`define CTRL_SINGLE 1
`define CTRL_RSEL 2
`define CTRL_ODRV 3
`define CTRL_RST 4'h3
// Read command fields
`define RCMD_READ 0
`define RCMD_RBACK 1
// Delay of a count update into the opposite side
`define SKEW_STAGES 1
`endif

// File: verilog/fifo_pkg.sv
package fifo_pkg;
   // Offset read-back sequencer
   typedef enum logic [0:0] {RB_IDLE, RB_SHIFT} readback_state_t;
   // Host read-back collector
   typedef enum logic [0:0] {HB_IDLE, HB_BUSY} host_rb_state_t;
endpackage : fifo_pkg

// File: verilog/fifo_link_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "fifo_params.svh"
interface fifo_link_if #(parameter int WIDTH = `FIFO_WIDTH);
   // Write side
   logic [WIDTH-1:0] wdata;
   logic write_n;
   logic write_select_n;
   logic full_flag_n;
   logic input_room_n;
   logic almost_full_n;
   // Read side
   logic read_n;
   logic read_select_n;
   logic out_drive_n;
   logic [WIDTH-1:0] data_out;
   logic data_out_oe;
   logic empty_flag_n;
   logic output_valid_n;
   logic echo_read_n;
   logic almost_empty_n;
   // Offset read-back and straps
   logic serial_offset_readback_n;
   logic serial_out;
   logic fall_through_mode;
   logic single_rate_mode;
   modport dev (
      input wdata, write_n, write_select_n, read_n, read_select_n,
      input out_drive_n, serial_offset_readback_n,
      input fall_through_mode, single_rate_mode,
      output full_flag_n, input_room_n, almost_full_n, data_out,
      output data_out_oe, empty_flag_n, output_valid_n, echo_read_n,
      output almost_empty_n, serial_out
   );
   modport host (
      output wdata, write_n, write_select_n, read_n, read_select_n,
      output out_drive_n, serial_offset_readback_n,
      output fall_through_mode, single_rate_mode,
      input full_flag_n, input_room_n, almost_full_n, data_out,
      input data_out_oe, empty_flag_n, output_valid_n, echo_read_n,
      input almost_empty_n, serial_out
   );
endinterface : fifo_link_if
`default_nettype wire

// File: verilog/event_delay.sv
`timescale 1ns/1ns
`default_nettype none
`include "fifo_params.svh"
module event_delay #(
   parameter int STAGES = `SKEW_STAGES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Event in and delayed event out
   input wire logic i_event,
   output logic o_event
);
   logic [STAGES-1:0] pipe_r;
   // Shift the event along the stages
   generate
      if (STAGES == 1) begin : g_one
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               pipe_r <= '0;
            end else begin
               pipe_r <= i_event;
            end
         end
      end else begin : g_many
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               pipe_r <= '0;
            end else begin
               pipe_r <= {pipe_r[STAGES-2:0], i_event};
            end
         end
      end
   endgenerate
   assign o_event = pipe_r[STAGES-1];
endmodule : event_delay
`default_nettype wire

// File: verilog/fifo_device.sv
`timescale 1ns/1ns
`default_nettype none
`include "fifo_params.svh"
// Operation
// - Host waits two cycles after select before strobe
// - First word falls through; later reads need both
// - Deselected reader advances read pointer only to fill the fall-through output register
// - Offset read-back always starts at first location
// - Standard echo is select OR strobe, high empty
// - Echo changes only on read clock edges
// - Fall-through echo pulses low per landed word
// - Fall-through echo low on any pop, with or without select and strobe
// - Bus driven only with select and drive low
// - Fall-through read past last word raises valid and echo
// - Almost-full updated on write edges only
// - Almost-empty updated on read edges only
// - Almost-full clears two cycles after read
// - Almost-empty clears two cycles after write
// - Fall-through depth is one word larger
// - Parallel devices need external composite flags
// - Cascade: valid drives next device write
// - Cascade: room drives preceding device read
// - Cascade empty latency follows ripple sum
// - Cascade full latency follows bubble sum
// - Cascade needs fall-through, single rate, free clocks
// - First word ripples through without reads
module fifo_device
   import fifo_pkg::*;
#(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int OFS_W = `OFS_W
) (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   // Link to the outside party
   fifo_link_if.dev LINK
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 2);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_C = CW'(1);
   localparam int RB_W = 2 * OFS_W;

   // Storage and pointers
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [CW-1:0] wcount_r;
   logic [CW-1:0] rcount_r;
   // Straps latched after reset
   logic strap_done_r;
   logic fall_r;
   logic single_r;
   // Output register
   logic [WIDTH-1:0] oreg_r;
   logic ov_r;
   // Offsets and read-back
   logic [OFS_W-1:0] aempty_ofs_r;
   logic [OFS_W-1:0] afull_ofs_r;
   logic [RB_W-1:0] rb_sh_r;
   logic [$clog2(RB_W+1)-1:0] rb_cnt_r;
   logic rb_prev_n_r;
   readback_state_t rb_state_r;
   // Registered outputs
   logic full_n_r;
   logic room_n_r;
   logic afull_n_r;
   logic empty_n_r;
   logic valid_n_r;
   logic echo_n_r;
   logic aempty_n_r;
   logic oe_r;
   logic sout_r;
   // Control terms
   logic wr_en;
   logic rd_req;
   logic pop;
   logic ov_clear;
   logic wr_seen;
   logic pop_seen;
   logic [CW-1:0] stored;

   // Pointer step with wrap at any depth
   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : next_ptr

   // Request decode
   assign wr_en = strap_done_r && !LINK.write_n && !LINK.write_select_n &&
                  (wcount_r != DEPTH_C);
   assign rd_req = !LINK.read_n && !LINK.read_select_n;
   // Fall-through fills an empty output register on its own
   assign pop = strap_done_r && (rcount_r != '0) &&
                (fall_r ? (!ov_r || rd_req) : rd_req);
   assign ov_clear = fall_r && ov_r && rd_req && (rcount_r == '0);
   // Output register counts as storage in fall-through
   assign stored = rcount_r + ((fall_r && ov_r) ? ONE_C : '0);

   // Each count hears the other side one cycle late
   event_delay #(.STAGES(`SKEW_STAGES)) u_wr_delay (
      .i_clk(I_REF_CLK),
      .i_rst(I_RESET),
      .i_event(wr_en),
      .o_event(wr_seen)
   );
   event_delay #(.STAGES(`SKEW_STAGES)) u_pop_delay (
      .i_clk(I_REF_CLK),
      .i_rst(I_RESET),
      .i_event(pop),
      .o_event(pop_seen)
   );

   // Mode straps caught at the first edge after release
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         strap_done_r <= 1'b0;
         fall_r <= 1'b0;
         single_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         fall_r <= LINK.fall_through_mode;
         single_r <= LINK.single_rate_mode;
      end
   end

   // Word storage
   always_ff @(posedge I_REF_CLK) begin
      if (wr_en) begin
         mem_r[wptr_r] <= LINK.wdata;
      end
   end

   // Pointers
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (wr_en) begin
            wptr_r <= next_ptr(wptr_r);
         end
         if (pop) begin
            rptr_r <= next_ptr(rptr_r);
         end
      end
   end

   // Write view and read view of the occupancy
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         wcount_r <= '0;
         rcount_r <= '0;
      end else begin
         wcount_r <= wcount_r + (wr_en ? ONE_C : '0) -
                     (pop_seen ? ONE_C : '0);
         rcount_r <= rcount_r + (wr_seen ? ONE_C : '0) -
                     (pop ? ONE_C : '0);
      end
   end

   // Output register and its valid state
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         oreg_r <= '0;
         ov_r <= 1'b0;
      end else if (pop) begin
         oreg_r <= mem_r[rptr_r];
         ov_r <= 1'b1;
      end else if (ov_clear) begin
         ov_r <= 1'b0;
      end
      // Otherwise the word stays put
   end

   // Write-edge flags
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         full_n_r <= 1'b1;
         room_n_r <= 1'b1;
         afull_n_r <= 1'b1;
      end else begin
         full_n_r <= (wcount_r != DEPTH_C);
         room_n_r <= !strap_done_r || (wcount_r == DEPTH_C);
         afull_n_r <= ((DEPTH_C - wcount_r) > CW'(afull_ofs_r));
      end
   end

   // Read-edge flags
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         empty_n_r <= 1'b0;
         valid_n_r <= 1'b1;
         aempty_n_r <= 1'b0;
      end else begin
         empty_n_r <= (rcount_r != '0);
         valid_n_r <= !(pop || (ov_r && !ov_clear));
         aempty_n_r <= (stored > CW'(aempty_ofs_r));
      end
   end

   // Echoed read strobe
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         echo_n_r <= 1'b1;
      end else if (fall_r) begin
         echo_n_r <= !pop;
      end else if (rcount_r == '0) begin
         echo_n_r <= 1'b1;
      end else begin
         echo_n_r <= LINK.read_select_n | LINK.read_n;
      end
   end

   // Bus drive enable
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= !LINK.read_select_n && !LINK.out_drive_n;
      end
   end

   // Offsets keep their reset values
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         aempty_ofs_r <= `AEMPTY_OFS_RST;
         afull_ofs_r <= `AFULL_OFS_RST;
      end else begin
         aempty_ofs_r <= aempty_ofs_r;
         afull_ofs_r <= afull_ofs_r;
      end
   end

   // Serial read-back of the offsets
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         rb_prev_n_r <= 1'b1;
         rb_state_r <= RB_IDLE;
         rb_sh_r <= '0;
         rb_cnt_r <= '0;
         sout_r <= 1'b0;
      end else begin
         rb_prev_n_r <= LINK.serial_offset_readback_n;
         if (LINK.serial_offset_readback_n) begin
            rb_state_r <= RB_IDLE;
         end else if (rb_prev_n_r) begin
            // Every start reloads from the first location
            rb_sh_r <= {afull_ofs_r, aempty_ofs_r};
            rb_cnt_r <= '0;
            rb_state_r <= RB_SHIFT;
         end else begin
            case (rb_state_r)
               RB_SHIFT: begin
                  sout_r <= rb_sh_r[0];
                  rb_sh_r <= {1'b0, rb_sh_r[RB_W-1:1]};
                  rb_cnt_r <= rb_cnt_r + 1'b1;
                  if (rb_cnt_r == ($clog2(RB_W+1))'(RB_W - 1)) begin
                     rb_state_r <= RB_IDLE;
                  end
               end
               default: rb_state_r <= RB_IDLE;
            endcase
         end
      end
   end

   // Link outputs
   assign LINK.full_flag_n = full_n_r;
   assign LINK.input_room_n = room_n_r;
   assign LINK.almost_full_n = afull_n_r;
   assign LINK.empty_flag_n = empty_n_r;
   assign LINK.output_valid_n = valid_n_r;
   assign LINK.echo_read_n = echo_n_r;
   assign LINK.almost_empty_n = aempty_n_r;
   assign LINK.data_out = oreg_r;
   assign LINK.data_out_oe = oe_r;
   assign LINK.serial_out = sout_r;
endmodule : fifo_device
`default_nettype wire

// File: verilog/fifo_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "fifo_params.svh"
module fifo_host
   import fifo_pkg::*;
#(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int OFS_W = `OFS_W
) (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   // AHB-Lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // Link to the device
   fifo_link_if.host LINK
);
   localparam int RB_W = 2 * OFS_W;
   localparam int HC_W = $clog2(RB_W + 3);

   logic [31:0] hrdata_r;
   logic [7:0] daddr_r;
   logic dwrite_r;
   logic [3:0] ctrl_r;
   logic [31:0] wlo_r;
   logic [WIDTH-33:0] whi_r;
   logic [WIDTH-1:0] rdata_r;
   logic wr_pend_r;
   logic rd_pend_r;
   logic write_n_r;
   logic read_n_r;
   logic sel_age_r;
   logic rb_n_r;
   logic [RB_W-1:0] rb_r;
   logic [HC_W-1:0] hcnt_r;
   host_rb_state_t hb_state_r;
   logic addr_ok;
   logic wr_cmd;
   logic rd_cmd;
   logic rb_cmd;
   logic room;
   logic [31:0] rd_mux;

   // Address phase accepted
   assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;
   assign wr_cmd = dwrite_r && (daddr_r == `REG_WHI);
   assign rd_cmd = dwrite_r && (daddr_r == `REG_RCMD) &&
                   I_HWDATA[`RCMD_READ];
   assign rb_cmd = dwrite_r && (daddr_r == `REG_RCMD) &&
                   I_HWDATA[`RCMD_RBACK];
   assign room = ctrl_r[`CTRL_FALL] ? !LINK.input_room_n
                                    : LINK.full_flag_n;

   // Read data for the decoded address
   always_comb begin
      case (I_HADDR[7:0])
         `REG_CTRL: rd_mux = {28'h0000000, ctrl_r};
         `REG_WLO: rd_mux = wlo_r;
         `REG_WHI: rd_mux = {{(64-WIDTH){1'b0}}, whi_r};
         `REG_RLO: rd_mux = rdata_r[31:0];
         `REG_RHI: rd_mux = {{(64-WIDTH){1'b0}}, rdata_r[WIDTH-1:32]};
         `REG_STAT: rd_mux = {22'h000000, hb_state_r == HB_BUSY,
                              rd_pend_r, wr_pend_r, LINK.echo_read_n,
                              LINK.almost_empty_n, LINK.almost_full_n,
                              LINK.output_valid_n, LINK.input_room_n,
                              LINK.empty_flag_n, LINK.full_flag_n};
         `REG_OFS: rd_mux = rb_r[31:0];
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Bus phases
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         daddr_r <= 8'h00;
         dwrite_r <= 1'b0;
         hrdata_r <= 32'h00000000;
      end else begin
         dwrite_r <= addr_ok && I_HWRITE;
         if (addr_ok) begin
            daddr_r <= I_HADDR[7:0];
         end
         if (addr_ok && !I_HWRITE) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   // Software registers
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         ctrl_r <= `CTRL_RST;
         wlo_r <= 32'h00000000;
         whi_r <= '0;
      end else if (dwrite_r) begin
         case (daddr_r)
            `REG_CTRL: ctrl_r <= I_HWDATA[3:0];
            `REG_WLO: wlo_r <= I_HWDATA;
            `REG_WHI: whi_r <= I_HWDATA[WIDTH-33:0];
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end

   // Push one word when the device has room
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         wr_pend_r <= 1'b0;
         write_n_r <= 1'b1;
      end else begin
         write_n_r <= !(wr_pend_r && room);
         if (wr_cmd) begin
            wr_pend_r <= 1'b1;
         end else if (wr_pend_r && room) begin
            wr_pend_r <= 1'b0;
         end
      end
   end

   // Strobe only after select has stood a full cycle
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         sel_age_r <= 1'b0;
         rd_pend_r <= 1'b0;
         read_n_r <= 1'b1;
      end else begin
         sel_age_r <= ctrl_r[`CTRL_RSEL];
         read_n_r <= !(rd_pend_r && sel_age_r && ctrl_r[`CTRL_RSEL]);
         if (rd_cmd) begin
            rd_pend_r <= 1'b1;
         end else if (rd_pend_r && sel_age_r && ctrl_r[`CTRL_RSEL]) begin
            rd_pend_r <= 1'b0;
         end
      end
   end

   // Latest word seen on the driven bus
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         rdata_r <= '0;
      end else if (LINK.data_out_oe) begin
         rdata_r <= LINK.data_out;
      end
   end

   // Offset read-back collector
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         hb_state_r <= HB_IDLE;
         rb_n_r <= 1'b1;
         hcnt_r <= '0;
         rb_r <= '0;
      end else begin
         case (hb_state_r)
            HB_IDLE: begin
               if (rb_cmd) begin
                  rb_n_r <= 1'b0;
                  hcnt_r <= '0;
                  hb_state_r <= HB_BUSY;
               end
            end
            HB_BUSY: begin
               hcnt_r <= hcnt_r + 1'b1;
               if (hcnt_r >= HC_W'(2)) begin
                  rb_r <= {LINK.serial_out, rb_r[RB_W-1:1]};
               end
               if (hcnt_r == HC_W'(RB_W + 1)) begin
                  rb_n_r <= 1'b1;
                  hb_state_r <= HB_IDLE;
               end
            end
            default: hb_state_r <= HB_IDLE;
         endcase
      end
   end

   // Bus and link outputs
   assign O_HRDATA = hrdata_r;
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP = 1'b0;
   assign LINK.wdata = {whi_r, wlo_r};
   assign LINK.write_n = write_n_r;
   assign LINK.write_select_n = 1'b0;
   assign LINK.read_n = read_n_r;
   assign LINK.read_select_n = !ctrl_r[`CTRL_RSEL];
   assign LINK.out_drive_n = !ctrl_r[`CTRL_ODRV];
   assign LINK.serial_offset_readback_n = rb_n_r;
   assign LINK.fall_through_mode = ctrl_r[`CTRL_FALL];
   assign LINK.single_rate_mode = ctrl_r[`CTRL_SINGLE];
endmodule : fifo_host
`default_nettype wire

// File: sim/fifo_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "fifo_params.svh"
module fifo_link_properties #(
   parameter int WIDTH = `FIFO_WIDTH
) (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   // Link signals
   input wire logic read_n,
   input wire logic read_select_n,
   input wire logic out_drive_n,
   input wire logic [WIDTH-1:0] data_out,
   input wire logic data_out_oe,
   input wire logic full_flag_n,
   input wire logic empty_flag_n,
   input wire logic output_valid_n,
   input wire logic echo_read_n,
   input wire logic almost_full_n,
   input wire logic almost_empty_n,
   input wire logic serial_offset_readback_n,
   input wire logic serial_out,
   input wire logic fall_through_mode
);
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RESET);
   // Bus drive one cycle after select and drive enable
   bus_drive_a: assert property (
      data_out_oe == $past(!read_select_n && !out_drive_n))
      else $error("bus drive mismatch");
   // Held word without a read advance
   word_hold_a: assert property (
      fall_through_mode && !output_valid_n && (read_n || read_select_n)
      |=> $stable(data_out)) else $error("output word moved");
   // Echo low only with a valid word
   echo_valid_a: assert property (
      fall_through_mode && !echo_read_n |-> !output_valid_n)
      else $error("echo low without word");
   // Read past the last word
   empty_echo_a: assert property (
      fall_through_mode && $rose(output_valid_n) |-> echo_read_n)
      else $error("echo low at read past end");
   // Landed word pulses echo
   land_echo_a: assert property (
      fall_through_mode && $fell(output_valid_n) |-> !echo_read_n)
      else $error("no echo for landed word");
   // Standard echo follows select and strobe
   std_echo_a: assert property (
      !fall_through_mode && (read_select_n || read_n) |=> echo_read_n)
      else $error("standard echo low");
   // Read-back starts with offset bit 0
   readback_a: assert property (
      $fell(serial_offset_readback_n) |-> ##[1:3] serial_out)
      else $error("read-back first bit wrong");
   // Full implies almost full
   full_flag_a: assert property (
      !full_flag_n |-> !almost_full_n) else $error("full without almost");
   // Empty implies almost empty
   empty_flag_a: assert property (
      !empty_flag_n |-> !almost_empty_n) else $error("empty without almost");
endmodule : fifo_link_properties
`default_nettype wire

// File: sim/test_dual_clock_fifo_read_flag_logic.sv
`timescale 1ns/1ns
`default_nettype none
`include "fifo_params.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
   bad_count++; $display("unexpected %s exp %h seen %h", n, e, g); end end
module test_dual_clock_fifo_read_flag_logic;
   localparam int DEPTH = 256;
   localparam int LIMIT = 30000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic dev_rst = 1'b0;
   logic dev_reset;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] q;
   logic [33:0] ofs = {`AFULL_OFS_RST, `AEMPTY_OFS_RST};
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int echo_lows = 0;
   int k;
   int e0;
   assign dev_reset = rst | dev_rst;
   fifo_link_if #(.WIDTH(`FIFO_WIDTH)) link ();
   fifo_host #(.WIDTH(`FIFO_WIDTH), .OFS_W(`OFS_W)) fifo_host_i (
      .I_REF_CLK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
      .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HRDATA(hrdata),
      .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .LINK(link));
   fifo_device #(.WIDTH(`FIFO_WIDTH), .DEPTH(DEPTH), .OFS_W(`OFS_W))
      fifo_device_i (.I_REF_CLK(clk), .I_RESET(dev_reset), .LINK(link));
   fifo_link_properties #(.WIDTH(`FIFO_WIDTH)) fifo_link_properties_i (
      .I_REF_CLK(clk), .I_RESET(dev_reset), .read_n(link.read_n),
      .read_select_n(link.read_select_n), .out_drive_n(link.out_drive_n),
      .data_out(link.data_out), .data_out_oe(link.data_out_oe),
      .full_flag_n(link.full_flag_n), .empty_flag_n(link.empty_flag_n),
      .output_valid_n(link.output_valid_n), .echo_read_n(link.echo_read_n),
      .almost_full_n(link.almost_full_n),
      .almost_empty_n(link.almost_empty_n),
      .serial_offset_readback_n(link.serial_offset_readback_n),
      .serial_out(link.serial_out),
      .fall_through_mode(link.fall_through_mode));
   // Clock
   always #20 clk = ~clk;
   // Cycle ceiling and echo pulse count
   always @(posedge clk) begin
      cycles++;
      if (link.echo_read_n === 1'b0) echo_lows++;
      if (cycles == LIMIT) begin
         bad_count++;
         stop_test();
      end
   end
   // Test word for an index
   function automatic logic [39:0] wd(input int i);
      return {8'hC3, 16'h5A00, i[15:0]};
   endfunction : wd
   // One AHB-Lite single word transfer
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   // Poll status, first read discarded as stale
   task automatic wait_stat(input logic [31:0] m, input logic [31:0] v,
                            output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         bus(1'b0, `REG_STAT, 32'h0);
         ok = (i > 0) && ((q & m) === v);
      end
   endtask : wait_stat
   // Queue one word for the link
   task automatic push(input logic [39:0] w);
      bus(1'b1, `REG_WLO, w[31:0]);
      bus(1'b1, `REG_WHI, {24'h0, w[39:32]});
   endtask : push
   // Take the shown word, then strobe the next one in
   task automatic get_word(output logic [39:0] w);
      bit ok;
      bus(1'b0, `REG_STAT, 32'h0);
      bus(1'b0, `REG_RLO, 32'h0);
      w[31:0] = q;
      bus(1'b0, `REG_RHI, 32'h0);
      w[39:32] = q[7:0];
      bus(1'b1, `REG_RCMD, 32'h1);
      wait_stat(32'h100, 32'h0, ok);
   endtask : get_word
   // Verdict and end of run
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   // Main sequence
   initial begin
      bit ok;
      logic [39:0] w;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      // Reset values and unmapped space
      bus(1'b0, `REG_CTRL, 32'h0);
      `CHK("ctrl", 32'h3, q)
      bus(1'b0, `REG_STAT, 32'h0);
      `CHK("status", 32'h59, q)
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      bus(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, q)
      `CHK("resp", 1'b0, hresp)
      $display("test reset done");
      // Fall-through while deselected, then select and read
      push(wd(1));
      push(wd(2));
      wait_stat(32'h8, 32'h0, ok);
      `CHK("landed", 1'b1, ok)
      `CHK("bus off", 1'b0, link.data_out_oe)
      bus(1'b1, `REG_CTRL, 32'hF);
      bus(1'b0, `REG_STAT, 32'h0);
      `CHK("bus on", 1'b1, link.data_out_oe)
      `CHK("first out", wd(1), link.data_out)
      for (int i = 1; i <= 2; i++) begin
         get_word(w);
         `CHK("word", wd(i), w)
      end
      wait_stat(32'h48, 32'h48, ok);
      `CHK("past end", 1'b1, ok)
      $display("test fall-through done");
      // Fill deselected until refused, flags on the way
      bus(1'b1, `REG_CTRL, 32'h3);
      e0 = echo_lows;
      k = 0;
      ok = 1'b1;
      while (ok && k < DEPTH + 8) begin
         push(wd(k + 16));
         wait_stat(32'h80, 32'h0, ok);
         if (ok) k++;
         if (k == 127) begin
            bus(1'b0, `REG_STAT, 32'h0);
            `CHK("aempty at 127", 1'b0, q[5])
         end
         if (k == 128) begin
            wait_stat(32'h20, 32'h20, ok);
            `CHK("aempty clear", 1'b1, ok)
         end
      end
      `CHK("capacity", DEPTH + 1, k)
      bus(1'b0, `REG_STAT, 32'h0);
      `CHK("full status", 32'h84, q & 32'h94)
      // Drain in order, the held word first
      bus(1'b1, `REG_CTRL, 32'hF);
      for (int i = 0; i <= k; i++) begin
         get_word(w);
         `CHK("order", wd(i + 16), w)
      end
      wait_stat(32'h38, 32'h18, ok);
      `CHK("drained flags", 1'b1, ok)
      `CHK("echo pulses", e0 + k + 1, echo_lows)
      $display("test depth done");
      // Offset read-back, twice from the start
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, `REG_RCMD, 32'h2);
         wait_stat(32'h200, 32'h200, ok);
         wait_stat(32'h200, 32'h0, ok);
         bus(1'b0, `REG_OFS, 32'h0);
         `CHK("offsets", ofs[31:0], q)
      end
      $display("test read-back done");
      // Standard mode echo after a device reset
      bus(1'b1, `REG_CTRL, 32'h2);
      dev_rst <= 1'b1;
      @(posedge clk);
      dev_rst <= 1'b0;
      repeat (2) @(posedge clk);
      push(wd(7));
      bus(1'b1, `REG_CTRL, 32'hE);
      wait_stat(32'h2, 32'h2, ok);
      for (int i = 0; i < 2; i++) begin
         e0 = echo_lows;
         bus(1'b1, `REG_RCMD, 32'h1);
         wait_stat(32'h100, 32'h0, ok);
         bus(1'b0, `REG_STAT, 32'h0);
         `CHK("std echo", e0 + 1 - i, echo_lows)
      end
      bus(1'b0, `REG_RLO, 32'h0);
      `CHK("std word", wd(7) & 40'hFFFF_FFFF, {8'h0, q})
      $display("test standard done");
      stop_test();
   end
endmodule : test_dual_clock_fifo_read_flag_logic
`default_nettype wire
